//--- ulab_pkg.sv
// constants and types for the serial port lin extensions
package ulab_pkg;
	// ------------------------------------------------------------
	// clock and divider constants
	// ------------------------------------------------------------
	localparam int CLK_HZ = 10000000;
	localparam int CLK_PERIOD_NS = 100;
	localparam logic [1:0] ABD_SEL_SLOW = 2'h0; // fosc/512
	localparam logic [1:0] ABD_SEL_MID = 2'h1; // fosc/128
	localparam logic [1:0] ABD_SEL_FAST = 2'h2; // fosc/32
	localparam logic [8:0] ABD_DIV_SLOW = 9'h1ff; // 512 - 1
	localparam logic [8:0] ABD_DIV_MID = 9'h07f; // 128 - 1
	localparam logic [8:0] ABD_DIV_FAST = 9'h01f; // 32 - 1
	localparam logic [8:0] PRE_ZERO = 9'h000;
	// ------------------------------------------------------------
	// autobaud counting
	// ------------------------------------------------------------
	localparam logic [15:0] ABD_COUNT_START = 16'h0001;
	localparam logic [15:0] ABD_COUNT_MAX = 16'hffff;
	localparam logic [2:0] ABD_LAST_EDGE = 3'h5;
	localparam logic [2:0] EDGE_ZERO = 3'h0;
	// ------------------------------------------------------------
	// transmit framing
	// ------------------------------------------------------------
	localparam logic [3:0] BREAK_ZERO_BITS = 4'hc;
	localparam logic [3:0] DATA_BITS = 4'h8;
	localparam logic [3:0] BITS_ZERO = 4'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] BAUD_ZERO = 16'h0000;
	// fosc/16 base period is the low divisor bit time in this sketch: (div+1)*16
	localparam logic [4:0] TX_OVERSAMPLE = 5'h10;
	// ------------------------------------------------------------
	// state machines
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_ABD_START = 5'h02,
		RX_ABD_COUNT = 5'h04,
		RX_WAKE_LOW = 5'h08,
		RX_RECEIVE = 5'h10
	} ulab_rx_state_type;
	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_START = 4'h2,
		TX_DATA = 4'h4,
		TX_STOP = 4'h8
	} ulab_tx_state_type;
endpackage : ulab_pkg

//--- ulab_prescaler.sv
// prescaler giving one tick every selected number of system clocks
`timescale 1ns/1ps
module ulab_prescaler (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_run,
	input wire logic [8:0] i_limit,
	output logic o_tick
);
	import ulab_pkg::*;
	logic [8:0] count;
	// count up to the limit, pulse, then wrap; held at zero while stopped
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || !i_run) begin
			count <= PRE_ZERO;
			o_tick <= 1'b0;
		end else if (count >= i_limit) begin
			count <= PRE_ZERO;
			o_tick <= 1'b1;
		end else begin
			count <= count + 9'h001;
			o_tick <= 1'b0;
		end
	end
endmodule : ulab_prescaler

//--- ulab_lin_port.sv
// lin extensions of an async serial port: autobaud, wake on break, break send
//
// Summary of operation
// RULE_01 - autobaud starts counting at first rising edge after start bit
// RULE_02 - fifth rising edge stores count, clears autobaud enable, sets receive flag
// RULE_03 - receive state machine stays idle during autobaud
// RULE_04 - both divisor bytes form one 16-bit counter during autobaud
// RULE_05 - counter ticks at base clock over eight per divider selects
// RULE_06 - counter starts at one; software subtracts one
// RULE_07 - reading receive data clears the receive flag after autobaud
// RULE_08 - counter wrap sets overflow flag; counting continues to fifth edge
// RULE_09 - overflow clear is ignored while autobaud enable is still set
// RULE_10 - with wake and autobaud both set, measure the byte after break
// RULE_11 - wake on break works only in asynchronous mode
// RULE_12 - wake enabled: reception off, falling edge is wake event
// RULE_13 - wake event sets receive flag; data read clears it
// RULE_14 - rising edge ending break clears wake enable, then idle
// RULE_15 - remote wake character is all zero, ten bit times or more
// RULE_16 - non-zero character: low time to first rise counts as wake
// RULE_17 - software checks receiver idle before enabling wake
// RULE_18 - break is start bit, twelve zeros, stop bit
// RULE_19 - break request plus transmit enable: data write starts a break
// RULE_20 - break request cleared after stop bit; preloaded byte goes next
// RULE_21 - shift register empty flag reflects break like normal transmit
// RULE_22 - master header: break, dummy write, 55h, next on buffer empty
// RULE_23 - clearing autobaud enable mid measurement aborts without receive flag
`timescale 1ns/1ps
module ulab_lin_port (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_receive_line,
	output logic o_transmit_line,
	input wire logic i_async_mode,
	input wire logic i_wide_divider_select,
	input wire logic i_high_speed_divider_select,
	input wire logic i_autobaud_enable_set,
	input wire logic i_autobaud_enable_clear,
	output logic o_autobaud_enable,
	input wire logic i_autobaud_overflow_clear,
	output logic o_autobaud_overflow_flag,
	input wire logic i_wake_on_break_enable_set,
	output logic o_wake_on_break_enable,
	output logic o_receiver_idle_flag,
	input wire logic i_divisor_write,
	input wire logic [15:0] i_divisor_wdata,
	output logic [15:0] o_divisor,
	input wire logic i_receive_data_read,
	output logic [7:0] o_receive_data_register,
	output logic o_receive_interrupt_flag,
	input wire logic i_transmit_enable,
	input wire logic i_send_break_request_set,
	output logic o_send_break_request,
	input wire logic i_transmit_data_write,
	input wire logic [7:0] i_transmit_data,
	output logic o_transmit_buffer_empty_flag,
	output logic o_shift_register_empty
);
	import ulab_pkg::*;

	// ------------------------------------------------------------
	// receive line edge detection
	// ------------------------------------------------------------
	logic rx_prev;
	logic rx_rise;
	logic rx_fall;
	// previous sample for edges; inputs are synchronous already
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			rx_prev <= 1'b1;
		end else begin
			rx_prev <= i_receive_line;
		end
	end
	assign rx_rise = i_receive_line && !rx_prev;
	assign rx_fall = !i_receive_line && rx_prev;

	// ------------------------------------------------------------
	// autobaud clock selection
	// ------------------------------------------------------------
	ulab_rx_state_type rx_state;
	logic [1:0] abd_sel;
	logic [8:0] abd_limit;
	logic abd_tick;
	logic abd_counting;
	// one eighth of the base clock, picked by the two selects
	always_comb begin
		abd_sel = {1'b0, i_wide_divider_select} + {1'b0, i_high_speed_divider_select};
		case (abd_sel)
			ABD_SEL_SLOW: abd_limit = ABD_DIV_SLOW; // RULE_05
			ABD_SEL_MID: abd_limit = ABD_DIV_MID; // RULE_05
			default: abd_limit = ABD_DIV_FAST; // RULE_05
		endcase
	end
	assign abd_counting = (rx_state == RX_ABD_COUNT);
	ulab_prescaler u_abd_prescaler (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_run(abd_counting),
		.i_limit(abd_limit),
		.o_tick(abd_tick)
	);

	// ------------------------------------------------------------
	// receive side state machine
	// ------------------------------------------------------------
	logic [2:0] rise_count;
	logic wake_armed;
	logic abd_done;
	logic abd_abort;
	logic wake_event;
	logic wake_end;
	logic [3:0] rx_bit_count;
	logic [15:0] rx_baud_count;
	logic [7:0] rx_shift;
	logic rx_byte_done;
	assign wake_armed = o_wake_on_break_enable && i_async_mode; // RULE_11
	assign abd_abort = i_autobaud_enable_clear
		&& (rx_state == RX_ABD_START || rx_state == RX_ABD_COUNT);
	assign abd_done = abd_counting && rx_rise && (rise_count == ABD_LAST_EDGE - 3'h1);
	assign wake_event = (rx_state == RX_IDLE) && wake_armed && rx_fall;
	assign wake_end = (rx_state == RX_WAKE_LOW) && rx_rise;

	// state transitions; wake takes priority over autobaud (measure after break)
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			rx_state <= RX_IDLE;
		end else begin
			case (rx_state)
				RX_IDLE: begin
					if (wake_event) begin
						rx_state <= RX_WAKE_LOW; // RULE_12 RULE_10
					end else if (wake_armed) begin
						rx_state <= RX_IDLE; // RULE_12
					end else if (o_autobaud_enable && rx_fall) begin
						rx_state <= RX_ABD_START; // RULE_03
					end else if (rx_fall && !o_autobaud_enable && i_async_mode) begin // RULE_11
						rx_state <= RX_RECEIVE;
					end
				end
				RX_WAKE_LOW: begin
					if (wake_end) begin
						rx_state <= RX_IDLE; // RULE_14 RULE_16
					end
				end
				RX_ABD_START: begin
					if (abd_abort) begin
						rx_state <= RX_IDLE; // RULE_23
					end else if (rx_rise) begin
						rx_state <= RX_ABD_COUNT; // RULE_01
					end
				end
				RX_ABD_COUNT: begin
					if (abd_abort || abd_done) begin
						rx_state <= RX_IDLE; // RULE_02 RULE_23
					end
				end
				RX_RECEIVE: begin
					if (rx_byte_done) begin
						rx_state <= RX_IDLE;
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// rising edges seen during the measurement
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || rx_state == RX_IDLE) begin
			rise_count <= EDGE_ZERO;
		end else if (rx_state == RX_ABD_START && rx_rise) begin
			rise_count <= 3'h1; // RULE_01
		end else if (abd_counting && rx_rise) begin
			rise_count <= rise_count + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// divisor pair: software value or 16-bit autobaud counter
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_divisor <= BAUD_ZERO;
		end else if (rx_state == RX_ABD_START && rx_rise && !abd_abort) begin
			o_divisor <= ABD_COUNT_START; // RULE_06 RULE_01
		end else if (abd_counting && abd_tick && !abd_done) begin
			o_divisor <= o_divisor + 16'h0001; // RULE_04 RULE_02
		end else if (i_divisor_write && !abd_counting) begin
			o_divisor <= i_divisor_wdata;
		end
	end

	// autobaud enable: set by software, cleared at completion or by software
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_autobaud_enable <= 1'b0;
		end else if (abd_done || i_autobaud_enable_clear) begin
			o_autobaud_enable <= 1'b0; // RULE_02 RULE_08
		end else if (i_autobaud_enable_set) begin
			o_autobaud_enable <= 1'b1;
		end
	end

	// overflow: set on wrap, clear only when autobaud enable is already low
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_autobaud_overflow_flag <= 1'b0;
		end else if (abd_counting && abd_tick && !abd_done && o_divisor == ABD_COUNT_MAX) begin
			o_autobaud_overflow_flag <= 1'b1; // RULE_08
		end else if (i_autobaud_overflow_clear && !o_autobaud_enable) begin
			o_autobaud_overflow_flag <= 1'b0; // RULE_09
		end
	end

	// wake enable: set by software, cleared by the rise ending the break
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_wake_on_break_enable <= 1'b0;
		end else if (wake_end) begin
			o_wake_on_break_enable <= 1'b0; // RULE_14
		end else if (i_wake_on_break_enable_set) begin
			o_wake_on_break_enable <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// minimal normal reception at the programmed divisor
	// ------------------------------------------------------------
	logic rx_bit_tick;
	assign rx_bit_tick = (rx_state == RX_RECEIVE)
		&& (rx_baud_count >= {o_divisor[11:0], 4'h0} + 16'h000f);
	assign rx_byte_done = rx_bit_tick && (rx_bit_count == DATA_BITS + 4'h1);
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || rx_state != RX_RECEIVE) begin
			rx_baud_count <= BAUD_ZERO;
			rx_bit_count <= BITS_ZERO;
		end else if (rx_bit_tick) begin
			rx_baud_count <= BAUD_ZERO;
			rx_bit_count <= rx_bit_count + 4'h1;
		end else begin
			rx_baud_count <= rx_baud_count + 16'h0001;
		end
	end
	// sample data bits on the bit ticks, which fall at the edge between bits
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			rx_shift <= BYTE_ZERO;
			o_receive_data_register <= BYTE_ZERO;
		end else if (rx_bit_tick && rx_bit_count != BITS_ZERO && rx_bit_count <= DATA_BITS) begin
			rx_shift <= {i_receive_line, rx_shift[7:1]};
		end else if (rx_byte_done) begin
			o_receive_data_register <= rx_shift;
		end
	end

	// receive flag: set wins over the read that clears it
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_receive_interrupt_flag <= 1'b0;
		end else if (abd_done || wake_event || rx_byte_done) begin
			o_receive_interrupt_flag <= 1'b1; // RULE_02 RULE_13 RULE_08
		end else if (i_receive_data_read) begin
			o_receive_interrupt_flag <= 1'b0; // RULE_07 RULE_13
		end
	end

	// idle flag for software before arming the wake
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_receiver_idle_flag <= 1'b1;
		end else begin
			o_receiver_idle_flag <= (rx_state == RX_IDLE);
		end
	end

	// ------------------------------------------------------------
	// transmitter with break support
	// ------------------------------------------------------------
	ulab_tx_state_type tx_state;
	logic [7:0] tx_hold;
	logic tx_hold_full;
	logic [7:0] tx_shift;
	logic tx_is_break;
	logic [3:0] tx_bit_count;
	logic [15:0] tx_baud_count;
	logic tx_bit_tick;
	logic tx_load;
	assign tx_bit_tick = (tx_state != TX_IDLE)
		&& (tx_baud_count >= {o_divisor[11:0], 4'h0} + 16'h000f);
	assign tx_load = (tx_state == TX_IDLE) && tx_hold_full && i_transmit_enable;

	// send break request: set by software, cleared after break stop bit
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_send_break_request <= 1'b0;
		end else if (tx_state == TX_STOP && tx_bit_tick && tx_is_break) begin
			o_send_break_request <= 1'b0; // RULE_20
		end else if (i_send_break_request_set) begin
			o_send_break_request <= 1'b1;
		end
	end

	// one-deep holding buffer ahead of the shifter
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			tx_hold <= BYTE_ZERO;
			tx_hold_full <= 1'b0;
		end else if (i_transmit_data_write) begin
			tx_hold <= i_transmit_data; // RULE_20
			tx_hold_full <= 1'b1;
		end else if (tx_load) begin
			tx_hold_full <= 1'b0;
		end
	end

	// frame sequencer: break sends twelve zeros, a normal byte sends eight
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			tx_state <= TX_IDLE;
			tx_shift <= BYTE_ZERO;
			tx_is_break <= 1'b0;
			tx_bit_count <= BITS_ZERO;
		end else begin
			case (tx_state)
				TX_IDLE: begin
					if (tx_load) begin
						tx_is_break <= o_send_break_request; // RULE_19
						tx_shift <= o_send_break_request ? BYTE_ZERO : tx_hold; // RULE_19
						tx_state <= TX_START;
					end
				end
				TX_START: begin
					if (tx_bit_tick) begin
						tx_bit_count <= BITS_ZERO;
						tx_state <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (tx_bit_tick) begin
						tx_shift <= {1'b0, tx_shift[7:1]};
						tx_bit_count <= tx_bit_count + 4'h1;
						if (tx_bit_count == (tx_is_break ? BREAK_ZERO_BITS : DATA_BITS) - 4'h1) begin
							tx_state <= TX_STOP; // RULE_18
						end
					end
				end
				TX_STOP: begin
					if (tx_bit_tick) begin
						tx_state <= TX_IDLE;
					end
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// bit timer at sixteen clocks per divisor step
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || tx_state == TX_IDLE || tx_bit_tick) begin
			tx_baud_count <= BAUD_ZERO;
		end else begin
			tx_baud_count <= tx_baud_count + 16'h0001;
		end
	end

	// line drive and status flags
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_transmit_line <= 1'b1;
			o_shift_register_empty <= 1'b1;
			o_transmit_buffer_empty_flag <= 1'b1;
		end else begin
			o_transmit_line <= (tx_state == TX_START) ? 1'b0
				: (tx_state == TX_DATA) ? tx_shift[0] : 1'b1; // RULE_18
			o_shift_register_empty <= (tx_state == TX_IDLE) && !tx_load; // RULE_21
			o_transmit_buffer_empty_flag <= !tx_hold_full || tx_load;
		end
	end
endmodule : ulab_lin_port

//--- ulab_lin_port_checker.sv
// concurrent checks on the lin port extensions
`timescale 1ns/1ps
module ulab_lin_port_checker (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_receive_line,
	input wire logic o_transmit_line,
	input wire logic i_async_mode,
	input wire logic i_wide_divider_select,
	input wire logic i_high_speed_divider_select,
	input wire logic i_autobaud_enable_clear,
	input wire logic o_autobaud_enable,
	input wire logic i_autobaud_overflow_clear,
	input wire logic o_autobaud_overflow_flag,
	input wire logic o_wake_on_break_enable,
	input wire logic [15:0] o_divisor,
	input wire logic o_receive_interrupt_flag,
	input wire logic o_send_break_request
);
	logic [9:0] gap;
	logic [9:0] gap_exp;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	// ----
	// helpers
	// ----
	// cycles since the divisor last moved
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || $changed(o_divisor)) begin
			gap <= 10'h000;
		end else begin
			gap <= gap + 10'h001;
		end
	end
	// tick spacing expected from the selects
	assign gap_exp = (i_wide_divider_select && i_high_speed_divider_select) ? 10'h01f :
		(i_wide_divider_select || i_high_speed_divider_select) ? 10'h07f : 10'h1ff;
	sequence wake_fall;
		o_wake_on_break_enable && i_async_mode && $fell(i_receive_line);
	endsequence
	sequence abd_done;
		$fell(o_autobaud_enable) && !$past(i_autobaud_enable_clear);
	endsequence
	// ----
	// assertions
	// ----
	a_wake_sets_flag: assert property (wake_fall |-> ##[1:3] o_receive_interrupt_flag)
		else $error("wake edge gave no receive flag");
	a_wake_end_clears: assert property (
		o_wake_on_break_enable && i_async_mode && $rose(i_receive_line)
		|-> ##[1:3] !o_wake_on_break_enable) else $error("wake enable not cleared");
	a_abd_count_step: assert property (
		o_autobaud_enable && $changed(o_divisor) && o_divisor != 16'h0001
		|-> o_divisor == $past(o_divisor) + 16'h0001) else $error("divisor step wrong");
	a_abd_tick_gap: assert property (
		o_autobaud_enable && $changed(o_divisor) && o_divisor > 16'h0002
		|-> gap == gap_exp) else $error("autobaud tick spacing wrong");
	a_abd_end_flag: assert property (abd_done |-> ##[0:1] o_receive_interrupt_flag)
		else $error("autobaud end gave no receive flag");
	a_abd_abort_quiet: assert property (
		i_autobaud_enable_clear && o_autobaud_enable && !o_receive_interrupt_flag
		|=> !o_autobaud_enable && !o_receive_interrupt_flag) else $error("abort misbehaved");
	a_ovf_clear_refused: assert property (
		o_autobaud_overflow_flag && o_autobaud_enable && i_autobaud_overflow_clear
		|=> o_autobaud_overflow_flag) else $error("overflow cleared while enabled");
	a_ovf_on_wrap: assert property (
		o_autobaud_enable && $past(o_divisor) == 16'hffff && o_divisor == 16'h0000
		|-> ##[0:1] o_autobaud_overflow_flag) else $error("wrap gave no overflow");
	a_break_low_run: assert property (
		$fell(o_transmit_line) && o_send_break_request |-> !o_transmit_line [*8])
		else $error("break not held low");
	a_break_end_high: assert property ($fell(o_send_break_request) |-> $past(o_transmit_line))
		else $error("break request cleared before stop bit");
endmodule : ulab_lin_port_checker

bind ulab_lin_port ulab_lin_port_checker i_checker (
	.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_receive_line(i_receive_line),
	.o_transmit_line(o_transmit_line), .i_async_mode(i_async_mode),
	.i_wide_divider_select(i_wide_divider_select),
	.i_high_speed_divider_select(i_high_speed_divider_select),
	.i_autobaud_enable_clear(i_autobaud_enable_clear), .o_autobaud_enable(o_autobaud_enable),
	.i_autobaud_overflow_clear(i_autobaud_overflow_clear),
	.o_autobaud_overflow_flag(o_autobaud_overflow_flag),
	.o_wake_on_break_enable(o_wake_on_break_enable), .o_divisor(o_divisor),
	.o_receive_interrupt_flag(o_receive_interrupt_flag),
	.o_send_break_request(o_send_break_request)
);

//--- ulab_remote_node.sv
// remote serial node: drives the receive line, samples the transmit line
`timescale 1ns/1ps
module ulab_remote_node (
	input wire logic i_clk_sys,
	input wire logic i_line_in,
	output logic o_line
);
	initial o_line = 1'b1; // line idles high between frames
	// ----
	// tasks
	// ----
	// drive n bits lsb first, bt clocks each, then release high
	task automatic send_bits(input logic [15:0] bits, input int n, input int bt);
		for (int i = 0; i < n; i++) begin
			o_line = bits[i];
			repeat (bt) @(negedge i_clk_sys);
		end
		o_line = 1'b1;
	endtask : send_bits
	// wait for a start edge, sample n bit centres; unknown when none comes
	task automatic grab(input int n, input int bt, output logic [15:0] v);
		int k;
		k = 0;
		v = 16'h0000;
		while (i_line_in !== 1'b0 && k < 5000) begin
			@(negedge i_clk_sys);
			k++;
		end
		repeat (bt / 2) @(negedge i_clk_sys);
		for (int i = 0; i < n; i++) begin
			if (i > 0) repeat (bt) @(negedge i_clk_sys);
			v[i] = i_line_in;
		end
		if (k == 5000) v = 16'hxxxx;
	endtask : grab
endmodule : ulab_remote_node

//--- test_uart_lin_autobaud_wake_break.sv
// self-checking bench for the lin port extensions
`timescale 1ns/1ps
module test_uart_lin_autobaud_wake_break;
	localparam int BT = 512; // remote bit time in clocks
	localparam int TBT = 32; // transmit bit time for divisor 1
	localparam logic [7:0] ABD_SET = 8'h01, ABD_CLR = 8'h02, OVF_CLR = 8'h04, WAKE = 8'h08;
	localparam logic [7:0] RD = 8'h10, BRK = 8'h20, TX_WR = 8'h40, DIV_WR = 8'h80;
	logic clk, rst_n, rx, tx, async_on, tx_en;
	logic [1:0] sel;
	logic [7:0] strobe, tx_data, rdata;
	logic abd_en, ovf, wake, idle, rx_flag, send_break_request, tbe, tsre;
	logic [15:0] divisor, v;
	int err_count, check_count, exp_div;
	ulab_lin_port i_dut (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_receive_line(rx), .o_transmit_line(tx),
		.i_async_mode(async_on), .i_wide_divider_select(sel[1]),
		.i_high_speed_divider_select(sel[0]), .i_autobaud_enable_set(strobe[0]),
		.i_autobaud_enable_clear(strobe[1]), .o_autobaud_enable(abd_en),
		.i_autobaud_overflow_clear(strobe[2]), .o_autobaud_overflow_flag(ovf),
		.i_wake_on_break_enable_set(strobe[3]), .o_wake_on_break_enable(wake),
		.o_receiver_idle_flag(idle), .i_divisor_write(strobe[7]), .i_divisor_wdata(16'h0001),
		.o_divisor(divisor), .i_receive_data_read(strobe[4]), .o_receive_data_register(rdata),
		.o_receive_interrupt_flag(rx_flag), .i_transmit_enable(tx_en),
		.i_send_break_request_set(strobe[5]), .o_send_break_request(send_break_request),
		.i_transmit_data_write(strobe[6]), .i_transmit_data(tx_data),
		.o_transmit_buffer_empty_flag(tbe), .o_shift_register_empty(tsre)
	);
	ulab_remote_node i_node (.i_clk_sys(clk), .i_line_in(tx), .o_line(rx));
	// ----
	// helpers
	// ----
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	// one-cycle strobe launched on a falling edge, then one quiet cycle
	task automatic pulse(input logic [7:0] m);
		strobe = m;
		@(negedge clk);
		strobe = 8'h00;
		@(negedge clk);
	endtask : pulse
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		$display("unexpected at %0t: run timed out", $time);
		print_verdict();
	end
	// main sequence
	initial begin
		{rst_n, tx_en, sel, strobe, tx_data, err_count, check_count} = '0;
		async_on = 1'b1;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		check(16'({abd_en, ovf, wake, idle, rx_flag, send_break_request, tbe, tsre, tx}), 16'h0027);
		check(divisor, 16'h0000);
		// wake on break, then autobaud on the following sync byte, each select
		for (int s = 0; s < 3; s++) begin
			sel = (s == 0) ? 2'b00 : (s == 1) ? 2'b01 : 2'b11;
			check(16'(idle), 16'h0001);
			pulse(WAKE | ABD_SET);
			fork
				i_node.send_bits(16'h0000, 13, BT);
				begin
					repeat (4) @(negedge clk);
					check(16'({rx_flag, wake}), 16'h0003);
					pulse(RD);
					check(16'(rx_flag), 16'h0000);
				end
			join
			repeat (4) @(negedge clk);
			check(16'({wake, abd_en, rx_flag}), 16'h0002);
			i_node.send_bits(16'({1'b1, 8'h55, 1'b0}), 10, BT);
			repeat (4) @(negedge clk);
			exp_div = 8 * BT / (512 >> (2 * s)) + 1;
			check(16'({abd_en, rx_flag}), 16'h0001);
			check(16'(divisor >= exp_div - 1 && divisor <= exp_div + 1), 16'h0001);
			pulse(RD);
			check(16'(rx_flag), 16'h0000);
			check(16'(rdata), 16'h0000);
		end
		// abort in mid measurement, then clear overflow
		pulse(ABD_SET);
		fork
			i_node.send_bits(16'({1'b1, 8'h55, 1'b0}), 10, BT);
			begin
				repeat (3 * BT) @(negedge clk);
				pulse(ABD_CLR);
				check(16'({abd_en, rx_flag}), 16'h0000);
				pulse(OVF_CLR);
				check(16'(ovf), 16'h0000);
			end
		join
		// master header: break, dummy byte, sync byte held behind it
		pulse(DIV_WR);
		tx_en = 1'b1;
		pulse(BRK);
		check(16'(send_break_request), 16'h0001);
		fork
			begin
				i_node.grab(14, TBT, v);
				check(v, 16'h2000);
				i_node.grab(10, TBT, v);
				check(v, 16'h02aa);
			end
			begin
				tx_data = 8'hff;
				pulse(TX_WR);
				tx_data = 8'h55;
				pulse(TX_WR);
				repeat (40) @(negedge clk);
				check(16'({tsre, send_break_request, tbe}), 16'h0002);
			end
		join
		repeat (TBT) @(negedge clk);
		check(16'({send_break_request, tbe, tsre}), 16'h0003);
		// no wake event outside asynchronous mode
		async_on = 1'b0;
		pulse(RD);
		pulse(WAKE);
		i_node.send_bits(16'h0000, 13, BT);
		repeat (4) @(negedge clk);
		check(16'({rx_flag, wake}), 16'h0001);
		print_verdict();
	end
endmodule : test_uart_lin_autobaud_wake_break
